/* include/clk_loader_pkg.sv */
package clk_loader_pkg;

   // =====================================================================
   // Word layout
   // =====================================================================
   localparam int WORD_BITS = 132;
   localparam logic [131:0] DEFAULT_WORD =
      132'h31FFDFFEE3BFFFFFFFFFFFFF655FF2;
   localparam int BIT_OE1 = 110;
   localparam int BIT_OE2 = 111;
   localparam int BIT_PWR = 112;
   localparam int BIT_SRC2 = 123;
   localparam int BIT_SRC3 = 124;
   localparam int BIT_OE3 = 129;

   // =====================================================================
   // Host register map (byte addresses, Avalon-MM)
   // =====================================================================
   localparam logic [4:0] ADDR_DATA0 = 5'h00;
   localparam logic [4:0] ADDR_DATA1 = 5'h04;
   localparam logic [4:0] ADDR_DATA2 = 5'h08;
   localparam logic [4:0] ADDR_DATA3 = 5'h0C;
   localparam logic [4:0] ADDR_DATA4 = 5'h10;
   localparam logic [4:0] ADDR_CTRL = 5'h14;
   localparam logic [4:0] ADDR_STATUS = 5'h18;
   localparam logic [7:0] SHIFT_DIV = 8'h02;
   localparam logic [7:0] STROBE_CYCLES = 8'h02;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_LOW    = 3'b001,
      ST_HIGH   = 3'b010,
      ST_STROBE = 3'b011,
      ST_DONE   = 3'b100
   } host_state_t;

endpackage

/* include/serial_cfg_if.sv */
`timescale 1ns/1ns
// Three-wire programming link between controller and device.
interface serial_cfg_if;
   logic shift_clk;
   logic shift_data;
   logic load_strobe;
   modport device (input shift_clk, input shift_data, input load_strobe);
   modport host (output shift_clk, output shift_data, output load_strobe);
endinterface

/* src/serial_clock_config_loader.sv */
`timescale 1ns/1ns
// What the document requires
// RULE1 - Word is 132 bits, sent MSB first
// RULE2 - Sample data on each shift clock rise
// RULE3 - Strobe high copies shift stage to active
// RULE4 - Host keeps strobe low while shifting
// RULE5 - Host keeps shift clock low during strobe
// RULE6 - Shift and load accepted even in power-down
// RULE7 - VCO/reference changes move output smoothly
// RULE8 - Output divider/mux changes may glitch
// RULE9 - Reset dividers 5, 50, 10, 2, 2
// RULE10 - Reset contents equal default programming word
// RULE11 - Default outputs run at 1x, 0.5x, 0.5x
// RULE12 - Output one is input times V/(R*OD)
// RULE13 - V 12..2055, R 1..2055
// RULE14 - Host keeps reference and VCO in range
// RULE15 - Bits 110,111,129 enable the three outputs
// RULE16 - Bit 112 low powers down the loop
// RULE17 - Shift stage separate from active register
module serial_clock_config_loader (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Programming link.
   serial_cfg_if.device      link,
   // Power-down pin, active low.
   input  wire logic         power_down_pin_n,
   // Active configuration and decoded controls.
   output logic [131:0]      frequency_control_word,
   output logic              first_output_enable,
   output logic              second_output_enable,
   output logic              third_output_enable,
   output logic              loop_running
);

   // ======================================================================
   // Input synchronisers
   // ======================================================================
   logic [1:0] sync_clk;
   logic [1:0] sync_dat;
   logic [1:0] sync_ld;
   logic [1:0] sync_pd;
   logic       clk_prev;
   logic [131:0] shift_stage;

   // Two flops on every pin before any logic reads it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_clk <= 2'h0;
         sync_dat <= 2'h0;
         sync_ld  <= 2'h0;
         sync_pd  <= 2'h3;
      end else begin
         sync_clk <= {sync_clk[0], link.shift_clk};
         sync_dat <= {sync_dat[0], link.shift_data};
         sync_ld  <= {sync_ld[0], link.load_strobe};
         sync_pd  <= {sync_pd[0], power_down_pin_n};
      end
   end

   // ======================================================================
   // Shift stage
   // ======================================================================
   // Samples data on the shift clock rise; power-down is not consulted.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_prev    <= 1'b0;
         shift_stage <= 132'h0;
      end else begin
         clk_prev <= sync_clk[1];
         if (sync_clk[1] && !clk_prev) begin
            shift_stage <= {shift_stage[130:0], sync_dat[1]}; // RULE1 RULE2 RULE6
         end
      end
   end

   // ======================================================================
   // Active control register
   // ======================================================================
   // Separate from the shift stage; it loads only while the synchronised strobe (sync_ld[1]) is high.
   // Loop divider changes settle smoothly in the analog loop, while output
   // divider and mux changes may glitch the outputs they feed.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         frequency_control_word <= clk_loader_pkg::DEFAULT_WORD; // RULE9 RULE10 RULE11
      end else if (sync_ld[1]) begin
         // The word carries the divider fields that set the output rate.
         frequency_control_word <= shift_stage; // RULE3 RULE6 RULE17 RULE7 RULE8 RULE12 RULE13
      end
   end

   // ======================================================================
   // Decoded controls
   // ======================================================================
   // Output enables and loop power; the pin also halts the loop.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         first_output_enable  <= 1'b0;
         second_output_enable <= 1'b0;
         third_output_enable  <= 1'b0;
         loop_running         <= 1'b0;
      end else begin
         first_output_enable  <=
            frequency_control_word[clk_loader_pkg::BIT_OE1]; // RULE15
         second_output_enable <=
            frequency_control_word[clk_loader_pkg::BIT_OE2]; // RULE15
         third_output_enable  <=
            frequency_control_word[clk_loader_pkg::BIT_OE3]; // RULE15
         loop_running <= frequency_control_word[clk_loader_pkg::BIT_PWR]
                         & sync_pd[1]; // RULE16
      end
   end

endmodule

/* src/serial_cfg_host.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Controller end: software fills five data words, then writes go.
module serial_cfg_host (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Avalon-MM slave.
   input  wire logic [4:0]   address,
   input  wire logic         read,
   input  wire logic         write,
   input  wire logic [31:0]  writedata,
   output logic [31:0]       readdata,
   output logic              waitrequest,
   // Programming link.
   serial_cfg_if.host        link
);

   logic [131:0]                word;
   logic [131:0]                shreg;
   logic [7:0]                  bit_cnt;
   logic [7:0]                  tick_cnt;
   clk_loader_pkg::host_state_t state;
   logic                        busy;
   logic                        answered;

   assign busy = (state != clk_loader_pkg::ST_IDLE);

   // ======================================================================
   // Bus slave
   // ======================================================================
   // One wait cycle per access; then the answer stands at the edge.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         answered    <= 1'b0;
      end else begin
         answered    <= (read | write) & ~answered;
         waitrequest <= ~((read | write) & ~answered & waitrequest);
      end
   end

   // Read data is latched in the wait cycle; a write lands only at the
   // edge where waitrequest stands low, so it matches the bus transfer.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         word     <= clk_loader_pkg::DEFAULT_WORD;
         readdata <= 32'h0;
      end else if ((read | write) & ~answered) begin
         unique case (address)
            clk_loader_pkg::ADDR_DATA0:  readdata <= word[31:0];
            clk_loader_pkg::ADDR_DATA1:  readdata <= word[63:32];
            clk_loader_pkg::ADDR_DATA2:  readdata <= word[95:64];
            clk_loader_pkg::ADDR_DATA3:  readdata <= word[127:96];
            clk_loader_pkg::ADDR_DATA4:  readdata <= {28'h0, word[131:128]};
            clk_loader_pkg::ADDR_STATUS: readdata <= {31'h0, busy};
            default:                     readdata <= 32'h0;
         endcase
      end else if (write & answered) begin
         unique case (address)
            clk_loader_pkg::ADDR_DATA0: word[31:0]    <= writedata;
            clk_loader_pkg::ADDR_DATA1: word[63:32]   <= writedata;
            clk_loader_pkg::ADDR_DATA2: word[95:64]   <= writedata;
            clk_loader_pkg::ADDR_DATA3: word[127:96]  <= writedata;
            clk_loader_pkg::ADDR_DATA4: word[131:128] <= writedata[3:0];
            default:                    word          <= word;
         endcase
      end
   end

   // ======================================================================
   // Serial sequencer
   // ======================================================================
   // Shifts 132 bits MSB first with the strobe low, then pulses the
   // strobe with the shift clock held low.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state            <= clk_loader_pkg::ST_IDLE;
         shreg            <= 132'h0;
         bit_cnt          <= 8'h00;
         tick_cnt         <= 8'h00;
         link.shift_clk   <= 1'b0;
         link.shift_data  <= 1'b0;
         link.load_strobe <= 1'b0;
      end else begin
         unique case (state)
            clk_loader_pkg::ST_IDLE: begin
               if (write & answered & ~busy & writedata[0] &&
                   address == clk_loader_pkg::ADDR_CTRL) begin
                  shreg           <= word;
                  link.shift_data <= word[131]; // RULE1
                  bit_cnt         <= 8'h00;
                  tick_cnt        <= 8'h00;
                  state           <= clk_loader_pkg::ST_LOW;
               end
            end
            clk_loader_pkg::ST_LOW: begin
               tick_cnt <= tick_cnt + 8'h01;
               if (tick_cnt == clk_loader_pkg::SHIFT_DIV) begin
                  link.shift_clk <= 1'b1; // RULE4
                  tick_cnt       <= 8'h00;
                  state          <= clk_loader_pkg::ST_HIGH;
               end
            end
            clk_loader_pkg::ST_HIGH: begin
               tick_cnt <= tick_cnt + 8'h01;
               if (tick_cnt == clk_loader_pkg::SHIFT_DIV) begin
                  link.shift_clk  <= 1'b0;
                  tick_cnt        <= 8'h00;
                  shreg           <= {shreg[130:0], 1'b0};
                  link.shift_data <= shreg[130];
                  bit_cnt         <= bit_cnt + 8'h01;
                  if (bit_cnt == 8'(clk_loader_pkg::WORD_BITS - 1))
                     state <= clk_loader_pkg::ST_STROBE;
                  else
                     state <= clk_loader_pkg::ST_LOW;
               end
            end
            clk_loader_pkg::ST_STROBE: begin
               tick_cnt <= tick_cnt + 8'h01;
               if (tick_cnt == clk_loader_pkg::SHIFT_DIV)
                  link.load_strobe <= 1'b1; // RULE5
               if (tick_cnt == clk_loader_pkg::SHIFT_DIV
                               + clk_loader_pkg::STROBE_CYCLES) begin
                  link.load_strobe <= 1'b0;
                  tick_cnt         <= 8'h00;
                  state            <= clk_loader_pkg::ST_DONE;
               end
            end
            clk_loader_pkg::ST_DONE: begin
               tick_cnt <= tick_cnt + 8'h01;
               if (tick_cnt == clk_loader_pkg::SHIFT_DIV)
                  state <= clk_loader_pkg::ST_IDLE;
            end
            default: state <= clk_loader_pkg::ST_IDLE;
         endcase
      end
   end

endmodule

/* verif/serial_cfg_sva.sv */
`timescale 1ns/1ns
// Watches the programming link and the active word beside it.
module serial_cfg_sva (
   // Clock and reset.
   input wire logic         clk,
   input wire logic         arst_n,
   // Link lines and active word.
   input wire logic         shift_clk,
   input wire logic         shift_data,
   input wire logic         load_strobe,
   input wire logic [131:0] frequency_control_word
);
   logic [7:0]   rises;
   logic [131:0] sh;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ==================================================================
   // Helpers
   // Counts shift clock rises since the last load.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rises <= 8'h00;
      end else if (load_strobe) begin
         rises <= 8'h00;
      end else if ($rose(shift_clk)) begin
         rises <= rises + 8'h01;
      end
   end
   // Keeps its own copy of the bits on the wire, oldest at the top.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sh <= '0;
      end else if ($rose(shift_clk)) begin
         sh <= {sh[130:0], shift_data};
      end
   end
   // ==================================================================
   // Assertions
   a_strobe_clk_low: assert property (load_strobe |-> !shift_clk)
      else $error("shift clock high during strobe");
   a_data_held: assert property (shift_clk |-> $stable(shift_data))
      else $error("data moved while shift clock high");
   a_clk_high_len: assert property ($rose(shift_clk) |->
      shift_clk[*3] ##1 !shift_clk) else $error("bad high phase");
   a_strobe_len: assert property ($rose(load_strobe) |->
      load_strobe[*2] ##1 !load_strobe) else $error("bad strobe width");
   a_strobe_full_word: assert property ($rose(load_strobe) |->
      rises == 8'h84) else $error("strobe without whole word");
   a_idle_after: assert property ($fell(load_strobe) |->
      (!shift_clk)[*3]) else $error("shifting too soon after strobe");
   a_word_held: assert property ((!load_strobe)[*5] |->
      $stable(frequency_control_word)) else $error("word moved unloaded");
   a_load_copies: assert property ($fell(load_strobe) |->
      ##3 frequency_control_word == sh) else $error("load lost bits");
   c_load: cover property ($rose(load_strobe));
   c_copy: cover property ($fell(load_strobe) ##3 frequency_control_word == sh);
   c_shift: cover property ($rose(shift_clk));
endmodule

/* verif/serial_clock_config_loader_test.sv */
`timescale 1ns/1ns
// Drives the controller over Avalon-MM and judges the device's word.
module serial_clock_config_loader_test;
   logic         clk = 1'b0;
   logic         arst_n = 1'b0;
   logic [4:0]   address = 5'h00;
   logic         read = 1'b0;
   logic         write = 1'b0;
   logic [31:0]  writedata = 32'h0;
   logic [31:0]  readdata;
   logic         waitrequest;
   logic         power_down_pin_n = 1'b1;
   logic [131:0] frequency_control_word;
   logic         first_output_enable;
   logic         second_output_enable;
   logic         third_output_enable;
   logic         loop_running;
   int           num_errors = 0;
   int           num_checks = 0;
   serial_cfg_if link_if();
   serial_cfg_host u_serial_cfg_host (.clk, .arst_n, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .link(link_if));
   serial_clock_config_loader u_serial_clock_config_loader (.clk, .arst_n,
      .link(link_if), .power_down_pin_n, .frequency_control_word,
      .first_output_enable, .second_output_enable, .third_output_enable,
      .loop_running);
   serial_cfg_sva u_serial_cfg_sva (.clk, .arst_n,
      .shift_clk(link_if.shift_clk), .shift_data(link_if.shift_data),
      .load_strobe(link_if.load_strobe), .frequency_control_word);
   // ==================================================================
   // Helpers
   // Makes the 10 MHz clock.
   always #50 clk = ~clk;
   // Compares one result and counts it.
   task automatic chk(input string nm, input logic [131:0] e,
                      input logic [131:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // One Avalon-MM transfer, held until waitrequest is seen low.
   task automatic bus(input logic we, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      write <= we;
      read <= !we;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0)
         num_errors++;
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic close_out;
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==================================================================
   // Scenarios
   // Checks the power-up word and an unmapped read.
   task automatic t_reset;
      logic [31:0] q;
      chk("word", clk_loader_pkg::DEFAULT_WORD, frequency_control_word);
      chk("oe1", clk_loader_pkg::DEFAULT_WORD[110], first_output_enable);
      bus(1'b0, 5'h1C, 32'h0, q);
      chk("unmapped", 132'h0, q);
   endtask
   // Sends one word, checking the old one holds while shifting.
   task automatic prog(input logic [131:0] w, input logic pin);
      logic [131:0] old;
      logic [159:0] x;
      logic [31:0]  q;
      old = frequency_control_word;
      x = {28'h0, w};
      power_down_pin_n <= pin;
      for (int i = 0; i < 5; i++)
         bus(1'b1, clk_loader_pkg::ADDR_DATA0 + 5'(4 * i), x[32*i+:32], q);
      bus(1'b1, clk_loader_pkg::ADDR_CTRL, 32'h1, q);
      repeat (200) @(posedge clk);
      chk("held", old, frequency_control_word);
      for (int i = 0; i < 600; i++) begin
         bus(1'b0, clk_loader_pkg::ADDR_STATUS, 32'h0, q);
         if (q[0] === 1'b0) break;
      end
      chk("busy", 132'h0, 132'(q[0]));
      repeat (6) @(posedge clk);
      chk("word", w, frequency_control_word);
      chk("oe1", w[110], first_output_enable);
      chk("oe2", w[111], second_output_enable);
      chk("oe3", w[129], third_output_enable);
      chk("loop", w[112] & pin, loop_running);
   endtask
   // Main sequence: reset, load while powered down, load again.
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      prog(~clk_loader_pkg::DEFAULT_WORD, 1'b0);
      prog(132'h8_0123_4567_89AB_CDEF_F0E1_D2C3_B4A5_9687, 1'b1);
      close_out();
   end
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out();
   end
endmodule
